// [common/arp_pkg.sv]
// Constants for the reset and power-mode sequencer of a six-channel converter.
// Assumes a 250 MHz system clock and a converter core outside this block.
// Overview of operation
// - Power-on or reset pin aborts running conversion
// - Master reset loads default word, sample mode
// - Standby pin low powers down analog sections
// - Register interface keeps working during standby
// - Standby leaves control word intact, no reset
// - Pair power-down bits switch each pair off
// - Reference stays on while any pair on
// - Pair power changes act right after update
// - Pair power-down only in software mode
// - Control-word bit 22 enables doze
// - Doze entered at busy falling edge
// - Start edge wakes, converts six cycles later
// - Doze conversion cycle spans 24.5 cycles
// - Reference stays active during doze
// - Control word default is 0x000003FF
// - Control word changes act at write
package arp_pkg;
   // Register map, byte addresses on the plain register port
   localparam int ADDR_W = 8;
   localparam int CW_W = 32;
   localparam logic [ADDR_W-1:0] CW_ADDR = 8'h00;
   localparam logic [ADDR_W-1:0] STAT_ADDR = 8'h04;
   // Control word layout and default
   localparam logic [CW_W-1:0] CW_DEFAULT = 32'h0000_03FF;
   localparam logic [CW_W-1:0] CW_WRITE_MASK = 32'hFFF7_EFFF;
   localparam int CW_DOZE_BIT = 22;
   localparam int CW_PD_LSB = 13;
   localparam int NUM_PAIRS = 3;
   // Status word bit positions
   localparam int ST_CORE_BIT = 0;
   localparam int ST_PAIR_LSB = 1;
   localparam int ST_REF_BIT = 4;
   localparam int ST_DOZE_BIT = 5;
   localparam int ST_READY_BIT = 6;
   localparam int ST_SAMPLE_BIT = 7;
   // Synchronised pin slots and their reset levels
   localparam int PIN_RST = 0;
   localparam int PIN_STANDBY_N_PIN = 1;
   localparam int PIN_CFG = 2;
   localparam int PIN_CS = 3;
   localparam logic [3:0] PIN_RESET_VAL = 4'h2;
   // Settling time after standby or pair power-up
   localparam int CLK_MHZ = 250;
   localparam int SETTLE_MS = 10;
   localparam int unsigned SETTLE_CYC = SETTLE_MS * CLK_MHZ * 1000;
   localparam int SETTLE_W = 22;
   // Doze timing in conversion-clock cycles, counted in half periods
   localparam int WAKE_CCLK = 6;
   localparam real CYCLE_CCLK = 24.5;
   localparam logic [5:0] WAKE_HALF = 6'(2 * WAKE_CCLK);
   localparam logic [5:0] CYCLE_HALF = 6'(int'(2.0 * CYCLE_CCLK));
   // Doze sequencer states
   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_DOZE = 3'b010,
      ST_WAKE = 3'b100
   } arp_doze_type;
endpackage

// [common/arp_settle_if.sv]
// Start and busy lines between the sequencer and its settling timers.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
interface arp_settle_if;
   logic [3:0] start; // One-cycle pulse per timer: slot 0 standby, 1..3 pairs
   logic [3:0] busy; // High while that interval is still running
   modport tmr (input start, output busy);
   modport ctl (output start, input busy);
endinterface

// [design/arp_settle_timer.sv]
// Four independent settling timers, restarted by a start pulse.
// Assumes start pulses come from logic on the same clock.
`timescale 1ns/10ps
module arp_settle_timer
   import arp_pkg::*;
#(
   parameter int unsigned SETTLE_LEN = SETTLE_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   arp_settle_if.tmr sif
);
   logic [SETTLE_W-1:0] cnt_reg [4]; // Cycles left per interval
   logic [SETTLE_W-1:0] cnt_next [4];

   // Restart wins over a running count, so a second power-up restarts the wait
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (sif.start[i]) begin
            cnt_next[i] = SETTLE_W'(SETTLE_LEN);
         end else if (cnt_reg[i] != '0) begin
            cnt_next[i] = cnt_reg[i] - 1'b1;
         end else begin
            cnt_next[i] = cnt_reg[i];
         end
      end
   end

   // Busy is a plain decode of the counters
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         sif.busy[i] = (cnt_reg[i] != '0);
      end
   end

   // Counters clear on system reset only
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < 4; i++) begin
         if (rst_i) begin
            cnt_reg[i] <= '0;
         end else begin
            cnt_reg[i] <= cnt_next[i];
         end
      end
   end
endmodule

// [design/arp_rst_pwr.sv]
// Reset, standby, pair power-down and doze sequencer of the converter.
// Assumes BUSY_I and CCLK_HALF_I come from converter logic on CLK_I;
// reset, standby, config select and convert-start arrive from pins.
`timescale 1ns/10ps
module arp_rst_pwr
   import arp_pkg::*;
#(
   parameter int unsigned SETTLE_LEN = SETTLE_CYC
) (
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire logic RESET_PIN_I,
   input wire logic STANDBY_N_PIN_I,
   input wire logic CONFIG_SOURCE_SELECT_I,
   input wire logic CONVERT_START_X_I,
   input wire logic BUSY_I,
   input wire logic CCLK_HALF_I,
   input wire logic [ADDR_W-1:0] ADDR_I,
   input wire logic [CW_W-1:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [CW_W-1:0] RDATA_O,
   output logic [CW_W-1:0] CONTROL_WORD_O,
   output logic CONV_ABORT_O,
   output logic CONV_START_O,
   output logic CYCLE_END_O,
   output logic SAMPLE_MODE_O,
   output logic DOZE_O,
   output logic CORE_POWER_O,
   output logic IF_ACTIVE_O,
   output logic [NUM_PAIRS-1:0] PAIR_POWER_O,
   output logic REF_POWER_O,
   output logic [NUM_PAIRS-1:0] PAIR_READY_O,
   output logic READY_O
);
   // Pin synchroniser chain
   logic [3:0] pin_in; // Raw pin levels gathered
   logic [3:0] s1_reg; // First stage, read only by s2
   logic [3:0] s2_reg;
   logic [3:0] s3_reg;
   logic [3:0] pin_reg; // Accepted levels
   logic [3:0] pin_next;
   // Control word and derived power state
   logic [CW_W-1:0] cw_reg;
   logic [CW_W-1:0] cw_next;
   logic master_rst; // Power-on or pin reset
   logic sw_mode; // Software configuration mode
   logic core_on; // Standby pin released
   logic [NUM_PAIRS-1:0] pd_eff; // Power-down bits that really apply
   logic [NUM_PAIRS-1:0] pair_on;
   logic standby_n_pin_rise;
   logic cs_rise;
   logic busy_fall;
   logic busy_prev_reg;
   // Doze sequencer
   arp_doze_type st_reg;
   arp_doze_type st_next;
   logic [5:0] hcnt_reg; // Conversion-clock half periods since wake
   logic [5:0] hcnt_next;
   logic start_next;
   logic end_next;
   logic sample_reg;
   logic sample_next;
   // Readiness and register port
   logic core_ready;
   logic [NUM_PAIRS-1:0] pair_ready;
   logic [CW_W-1:0] status;
   logic [CW_W-1:0] rdata_next;

   arp_settle_if sif ();

   arp_settle_timer #(
      .SETTLE_LEN(SETTLE_LEN)
   ) u_settle (
      .clk_i(CLK_I),
      .rst_i(SYS_RST_I),
      .sif(sif.tmr)
   );

   // Gather pins into the synchroniser slots
   always_comb begin
      pin_in = '0;
      pin_in[PIN_RST] = RESET_PIN_I;
      pin_in[PIN_STANDBY_N_PIN] = STANDBY_N_PIN_I;
      pin_in[PIN_CFG] = CONFIG_SOURCE_SELECT_I;
      pin_in[PIN_CS] = CONVERT_START_X_I;
   end

   // A level is accepted once the last two stages agree, filtering a lone glitch
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pin_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : pin_reg[i];
      end
   end

   // Synchroniser registers, loaded with PIN_RESET_VAL only by power-on reset
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         s1_reg <= PIN_RESET_VAL;
         s2_reg <= PIN_RESET_VAL;
         s3_reg <= PIN_RESET_VAL;
         pin_reg <= PIN_RESET_VAL;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         pin_reg <= pin_next;
      end
   end

   // Both reset sources act alike on the control word, the sequencer and the abort pulse
   assign master_rst = SYS_RST_I | pin_reg[PIN_RST];
   assign sw_mode = pin_reg[PIN_CFG];
   assign core_on = pin_reg[PIN_STANDBY_N_PIN];
   assign cs_rise = pin_next[PIN_CS] & ~pin_reg[PIN_CS];
   assign standby_n_pin_rise = pin_next[PIN_STANDBY_N_PIN] & ~pin_reg[PIN_STANDBY_N_PIN];
   assign busy_fall = busy_prev_reg & ~BUSY_I;

   // Control word: writes only in software mode, take effect on the next edge.
   // Standby never touches it, so no reset is needed after wake-up.
   always_comb begin
      cw_next = cw_reg;
      if (WR_I && ADDR_I == CW_ADDR && sw_mode) begin
         cw_next = WDATA_I & CW_WRITE_MASK;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (master_rst) begin
         cw_reg <= CW_DEFAULT;
      end else begin
         cw_reg <= cw_next;
      end
   end

   // Pair power-down bits only count in software mode
   always_comb begin
      pd_eff = sw_mode ? cw_reg[CW_PD_LSB +: NUM_PAIRS] : '0;
      pair_on = {NUM_PAIRS{core_on}} & ~pd_eff;
   end

   // Settling timers restart on standby release or on a pair turning on
   always_comb begin
      sif.start = '0;
      sif.start[0] = standby_n_pin_rise;
      for (int i = 0; i < NUM_PAIRS; i++) begin
         sif.start[i+1] = pair_on[i] & ~PAIR_POWER_O[i];
      end
   end

   // Ready only when powered and no interval is still running
   always_comb begin
      core_ready = core_on & ~sif.busy[0];
      for (int i = 0; i < NUM_PAIRS; i++) begin
         pair_ready[i] = core_ready & pair_on[i] & ~sif.busy[i+1];
      end
   end

   // Doze sequencer and conversion-start pacing
   always_comb begin
      st_next = st_reg;
      hcnt_next = hcnt_reg;
      start_next = 1'b0;
      end_next = 1'b0;
      sample_next = sample_reg;
      if (busy_fall) begin
         sample_next = 1'b1;
      end
      case (st_reg)
         ST_RUN: begin
            if (cw_reg[CW_DOZE_BIT] && busy_fall) begin
               st_next = ST_DOZE;
            end else if (cs_rise && core_on) begin
               start_next = 1'b1; // Normal mode converts on the edge
               sample_next = 1'b0;
            end
         end
         ST_DOZE: begin
            if (!cw_reg[CW_DOZE_BIT]) begin
               st_next = ST_RUN;
            end else if (cs_rise && core_on) begin
               st_next = ST_WAKE;
               hcnt_next = '0;
            end
         end
         ST_WAKE: begin
            if (CCLK_HALF_I) begin
               hcnt_next = hcnt_reg + 1'b1;
               if (hcnt_next == WAKE_HALF) begin
                  start_next = 1'b1;
                  sample_next = 1'b0;
               end
               if (hcnt_next == CYCLE_HALF) begin
                  end_next = 1'b1;
                  st_next = ST_RUN;
               end
            end
            // The converter's own end of conversion also sends it back to doze
            if (busy_fall && cw_reg[CW_DOZE_BIT]) begin
               st_next = ST_DOZE;
            end
         end
         default: begin
            st_next = ST_RUN;
         end
      endcase
   end

   // Sequencer registers; master reset aborts and returns to sampling
   always_ff @(posedge CLK_I) begin
      if (master_rst) begin
         st_reg <= ST_RUN;
         hcnt_reg <= '0;
         sample_reg <= 1'b1;
         busy_prev_reg <= 1'b0;
         CONV_START_O <= 1'b0;
         CYCLE_END_O <= 1'b0;
      end else begin
         st_reg <= st_next;
         hcnt_reg <= hcnt_next;
         sample_reg <= sample_next;
         busy_prev_reg <= BUSY_I;
         CONV_START_O <= start_next;
         CYCLE_END_O <= end_next;
      end
   end

   // Abort pulse follows any master reset so the core drops its conversion
   always_ff @(posedge CLK_I) begin
      CONV_ABORT_O <= master_rst;
   end

   // Status word assembled from live state
   always_comb begin
      status = '0;
      status[ST_CORE_BIT] = core_on;
      status[ST_PAIR_LSB +: NUM_PAIRS] = pair_on;
      status[ST_REF_BIT] = core_on & (|pair_on);
      status[ST_DOZE_BIT] = (st_reg == ST_DOZE);
      status[ST_READY_BIT] = READY_O;
      status[ST_SAMPLE_BIT] = sample_reg;
   end

   // Register read: data stand in the cycle after the strobe, zero otherwise.
   // The port has no power gating, so it answers in standby as well.
   always_comb begin
      rdata_next = '0;
      if (RD_I) begin
         case (ADDR_I)
            CW_ADDR: begin
               rdata_next = cw_reg;
            end
            STAT_ADDR: begin
               rdata_next = status;
            end
            default: begin
               rdata_next = '0;
            end
         endcase
      end
   end

   // Power outputs, registered; reference follows any powered pair, and
   // doze never powers pairs down, so it stays on through doze
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         RDATA_O <= '0;
         CONTROL_WORD_O <= CW_DEFAULT;
         SAMPLE_MODE_O <= 1'b1;
         DOZE_O <= 1'b0;
         CORE_POWER_O <= 1'b0;
         IF_ACTIVE_O <= 1'b1;
         PAIR_POWER_O <= '0;
         REF_POWER_O <= 1'b0;
         PAIR_READY_O <= '0;
         READY_O <= 1'b0;
      end else begin
         RDATA_O <= rdata_next;
         // A master reset overrides a write or a start that falls in the same cycle
         CONTROL_WORD_O <= master_rst ? CW_DEFAULT : cw_next;
         SAMPLE_MODE_O <= master_rst ? 1'b1 : sample_next;
         DOZE_O <= !master_rst && (st_next == ST_DOZE);
         CORE_POWER_O <= core_on;
         IF_ACTIVE_O <= 1'b1;
         PAIR_POWER_O <= pair_on;
         REF_POWER_O <= core_on & (|pair_on);
         PAIR_READY_O <= pair_ready;
         READY_O <= core_ready & (&(pair_ready | ~pair_on));
      end
   end
endmodule

// [verif/arp_host_model.sv]
// Far-side model: host pins (reset, standby, convert start) and the conversion-clock tick.
// Assumes the testbench calls its tasks; every pin changes just after a rising edge.
`timescale 1ns/10ps
module arp_host_model #(
   parameter int unsigned SETTLE_LEN = 20
) (
   input wire logic clk_i,
   output logic rst_pin_o,
   output logic standby_n_pin_n_o,
   output logic cs_o,
   output logic half_o
);
   // Idle pin levels: no reset, powered, no start
   initial begin
      rst_pin_o = 1'b0;
      standby_n_pin_n_o = 1'b1;
      cs_o = 1'b0;
      half_o = 1'b0;
   end
   // Half-period tick every second cycle, free running like a real conversion clock
   always @(posedge clk_i) half_o <= !half_o;
   // Set the reset and standby pins together
   task automatic pins(input logic rst, input logic standby_n_pin_n);
      @(posedge clk_i);
      rst_pin_o <= rst;
      standby_n_pin_n_o <= standby_n_pin_n;
   endtask
   // Host waits out the settling time before it starts anything new
   task automatic settle();
      repeat (SETTLE_LEN + 8) @(posedge clk_i);
   endtask
   // Start edge held long enough to pass the pin synchroniser
   task automatic start();
      @(posedge clk_i);
      cs_o <= 1'b1;
      repeat (6) @(posedge clk_i);
      cs_o <= 1'b0;
   endtask
endmodule

// [verif/arp_rst_pwr_checker.sv]
// Port checker for the reset and power-mode sequencer.
// Assumes it is bound onto arp_rst_pwr; one clock, synchronous reset.
`timescale 1ns/10ps
module arp_rst_pwr_checker
   import arp_pkg::*;
#(
   parameter int unsigned SETTLE_LEN = SETTLE_CYC
) (
   input wire logic CLK_I, SYS_RST_I, RESET_PIN_I, STANDBY_N_PIN_I,
   input wire logic CONFIG_SOURCE_SELECT_I, BUSY_I, CCLK_HALF_I, WR_I, RD_I,
   input wire logic [ADDR_W-1:0] ADDR_I,
   input wire logic [CW_W-1:0] RDATA_O, CONTROL_WORD_O,
   input wire logic CONV_ABORT_O, CONV_START_O, CYCLE_END_O, SAMPLE_MODE_O,
   input wire logic DOZE_O, CORE_POWER_O, REF_POWER_O, READY_O,
   input wire logic [NUM_PAIRS-1:0] PAIR_POWER_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SYS_RST_I);
   logic [2:0] age_reg; // Cycles since reset, saturating
   logic [2:0] cfg_reg; // Cycles since config pin moved, saturating
   logic [5:0] half_reg; // Half ticks counted since doze wake
   logic wake_reg; // Between doze wake and cycle end
   // Helper counters; config age guards against the pin synchroniser lag
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         age_reg <= 3'h0;
         cfg_reg <= 3'h0;
         wake_reg <= 1'b0;
         half_reg <= 6'h0;
      end else begin
         age_reg <= (age_reg == 3'h7) ? age_reg : age_reg + 3'h1;
         cfg_reg <= $changed(CONFIG_SOURCE_SELECT_I) ? 3'h0 : ((cfg_reg == 3'h7) ? cfg_reg : cfg_reg + 3'h1);
         if ($fell(DOZE_O)) begin
            wake_reg <= 1'b1;
            half_reg <= 6'(CCLK_HALF_I);
         end else if (CYCLE_END_O) begin
            wake_reg <= 1'b0;
         end else if (wake_reg) begin
            half_reg <= half_reg + 6'(CCLK_HALF_I);
         end
      end
   end
   wire warm = age_reg == 3'h7;
   wire sw_ok = cfg_reg == 3'h7 && CONFIG_SOURCE_SELECT_I;
   wire hw_ok = cfg_reg == 3'h7 && !CONFIG_SOURCE_SELECT_I;
   sequence cw_write_s;
      WR_I && ADDR_I == CW_ADDR && sw_ok && CORE_POWER_O ##1 !WR_I;
   endsequence
   sequence pin_reset_s;
      RESET_PIN_I [*8];
   endsequence
   cw_default_a: assert property ($fell(SYS_RST_I) |-> CONTROL_WORD_O == CW_DEFAULT && SAMPLE_MODE_O)
      else $error("control word not default after reset");
   pin_reset_a: assert property (pin_reset_s |-> CONV_ABORT_O && CONTROL_WORD_O == CW_DEFAULT && SAMPLE_MODE_O)
      else $error("reset pin did not act as master reset");
   standby_core_a: assert property (!STANDBY_N_PIN_I [*8] |-> !CORE_POWER_O)
      else $error("core powered in standby");
   read_cw_a: assert property (RD_I && ADDR_I == CW_ADDR |=> RDATA_O == $past(CONTROL_WORD_O))
      else $error("control word readback wrong");
   pd_write_a: assert property (cw_write_s |=> PAIR_POWER_O == ~CONTROL_WORD_O[CW_PD_LSB +: NUM_PAIRS])
      else $error("pair power does not follow its bits");
   hw_refuse_a: assert property (WR_I && hw_ok |=> $stable(CONTROL_WORD_O))
      else $error("write taken in hardware mode");
   ref_power_a: assert property ($stable(PAIR_POWER_O) && $stable(CORE_POWER_O)
      |-> REF_POWER_O == (CORE_POWER_O && |PAIR_POWER_O))
      else $error("reference power wrong");
   doze_entry_a: assert property ($fell(BUSY_I) && CONTROL_WORD_O[CW_DOZE_BIT] && CORE_POWER_O |=> DOZE_O)
      else $error("doze not entered at busy fall");
   doze_off_a: assert property ($fell(BUSY_I) && !CONTROL_WORD_O[CW_DOZE_BIT] && !DOZE_O |=> !DOZE_O)
      else $error("doze entered while disabled");
   wake_start_a: assert property (CONV_START_O && wake_reg |-> half_reg == 6'd12)
      else $error("start after wake mistimed");
   cycle_len_a: assert property (CYCLE_END_O |-> wake_reg && half_reg == 6'd49)
      else $error("doze cycle length wrong");
   settle_core_a: assert property (warm && $rose(CORE_POWER_O) |-> ##2 !READY_O [*6])
      else $error("ready during settling");
endmodule
bind arp_rst_pwr arp_rst_pwr_checker #(.SETTLE_LEN(SETTLE_LEN)) i_chk (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
   .RESET_PIN_I(RESET_PIN_I), .STANDBY_N_PIN_I(STANDBY_N_PIN_I), .CONFIG_SOURCE_SELECT_I(CONFIG_SOURCE_SELECT_I),
   .BUSY_I(BUSY_I), .CCLK_HALF_I(CCLK_HALF_I), .WR_I(WR_I), .RD_I(RD_I), .ADDR_I(ADDR_I), .RDATA_O(RDATA_O),
   .CONTROL_WORD_O(CONTROL_WORD_O), .CONV_ABORT_O(CONV_ABORT_O), .CONV_START_O(CONV_START_O),
   .CYCLE_END_O(CYCLE_END_O), .SAMPLE_MODE_O(SAMPLE_MODE_O), .DOZE_O(DOZE_O), .CORE_POWER_O(CORE_POWER_O),
   .REF_POWER_O(REF_POWER_O), .READY_O(READY_O), .PAIR_POWER_O(PAIR_POWER_O));

// [verif/testbench.sv]
// Self-checking bench for the reset and power-mode sequencer.
// Assumes a short settling parameter; host pins come from the partner model.
`timescale 1ns/10ps
module testbench;
   import arp_pkg::*;
   localparam int unsigned SETTLE = 20; // Shortened settling interval
   logic clk, rst, cfg, busy, wr, rd, rst_pin, standby_n_pin_n, cs, half;
   logic abort, cstart, cend, sample, doze, core, ifa, refp, ready;
   logic [ADDR_W-1:0] addr;
   logic [CW_W-1:0] wdata, rdata, cw, got;
   logic [NUM_PAIRS-1:0] pp, pr;
   int error_cnt = 0;
   int samples_checked = 0;
   arp_host_model #(.SETTLE_LEN(SETTLE)) i_host (.clk_i(clk), .rst_pin_o(rst_pin), .standby_n_pin_n_o(standby_n_pin_n),
      .cs_o(cs), .half_o(half));
   arp_rst_pwr #(.SETTLE_LEN(SETTLE)) i_dut (.CLK_I(clk), .SYS_RST_I(rst), .RESET_PIN_I(rst_pin),
      .STANDBY_N_PIN_I(standby_n_pin_n), .CONFIG_SOURCE_SELECT_I(cfg), .CONVERT_START_X_I(cs), .BUSY_I(busy),
      .CCLK_HALF_I(half), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
      .CONTROL_WORD_O(cw), .CONV_ABORT_O(abort), .CONV_START_O(cstart), .CYCLE_END_O(cend),
      .SAMPLE_MODE_O(sample), .DOZE_O(doze), .CORE_POWER_O(core), .IF_ACTIVE_O(ifa), .PAIR_POWER_O(pp),
      .REF_POWER_O(refp), .PAIR_READY_O(pr), .READY_O(ready));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Compare and count; unknowns never match
   task automatic chk(input string what, input logic [CW_W-1:0] seen, input logic [CW_W-1:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   // Let n edges pass, then settle past the updates
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr_cw(input logic [CW_W-1:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= CW_ADDR;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [ADDR_W-1:0] a);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      got = rdata;
   endtask
   task automatic t_reset();
      rd_reg(CW_ADDR);
      chk("cw after reset", got, CW_DEFAULT);
      chk("sample mode", 32'(sample), 32'h0000_0001);
      $display("reset test done");
   endtask
   task automatic t_pairs();
      wr_cw(32'h0000_A3FF);
      step(2);
      chk("pairs on", 32'(pp), 32'h0000_0002);
      chk("ref on", 32'(refp), 32'h0000_0001);
      wr_cw(32'h0008_F3FF);
      step(2);
      chk("ref off", 32'(refp), 32'h0000_0000);
      rd_reg(CW_ADDR);
      chk("cw masked", got, 32'h0008_F3FF & CW_WRITE_MASK);
      wr_cw(CW_DEFAULT);
      step(2);
      chk("pairs settling", 32'(pr), 32'h0000_0000);
      i_host.settle();
      step(1);
      chk("pairs ready", 32'(pr), 32'h0000_0007);
      $display("pair test done");
   endtask
   task automatic t_hw();
      // All pairs down in software mode, so hardware mode must visibly ignore the bits
      wr_cw(32'h0000_E3FF);
      step(2);
      chk("pairs all down", 32'(pp), 32'h0000_0000);
      cfg <= 1'b0;
      step(8);
      wr_cw(32'h0000_E000);
      rd_reg(CW_ADDR);
      chk("cw hw write", got, 32'h0000_E3FF);
      chk("pairs hw", 32'(pp), 32'h0000_0007);
      rd_reg(8'h08);
      chk("unmapped", got, 32'h0000_0000);
      cfg <= 1'b1;
      step(8);
      chk("pairs sw again", 32'(pp), 32'h0000_0000);
      wr_cw(CW_DEFAULT);
      step(2);
      $display("hardware mode test done");
   endtask
   task automatic t_standby_n_pin();
      i_host.pins(1'b0, 1'b0);
      step(8);
      chk("core standby", 32'(core), 32'h0000_0000);
      chk("if active", 32'(ifa), 32'h0000_0001);
      rd_reg(CW_ADDR);
      chk("cw standby", got, CW_DEFAULT);
      rd_reg(STAT_ADDR);
      chk("status standby", got, 32'h0000_0080);
      i_host.pins(1'b0, 1'b1);
      step(8);
      chk("core back", 32'(core), 32'h0000_0001);
      chk("settling", 32'(ready), 32'h0000_0000);
      i_host.settle();
      step(1);
      chk("settled", 32'(ready), 32'h0000_0001);
      $display("standby test done");
   endtask
   task automatic t_doze();
      int n;
      wr_cw(CW_DEFAULT | 32'h0040_0000);
      busy <= 1'b1;
      step(2);
      busy <= 1'b0;
      step(2);
      chk("doze in", 32'(doze), 32'h0000_0001);
      chk("ref in doze", 32'(refp), 32'h0000_0001);
      i_host.start();
      for (n = 0; n < 60 && cstart !== 1'b1; n++) step(1);
      chk("wake start", 32'(cstart), 32'h0000_0001);
      for (n = 0; n < 200 && cend !== 1'b1; n++) step(1);
      chk("cycle span", 32'(n), 32'd74);
      wr_cw(CW_DEFAULT);
      busy <= 1'b1;
      step(2);
      busy <= 1'b0;
      step(2);
      chk("doze off", 32'(doze), 32'h0000_0000);
      $display("doze test done");
   endtask
   task automatic t_pinrst();
      wr_cw(CW_DEFAULT | 32'h0040_0000);
      i_host.pins(1'b1, 1'b1);
      step(8);
      chk("abort", 32'(abort), 32'h0000_0001);
      i_host.pins(1'b0, 1'b1);
      step(8);
      rd_reg(CW_ADDR);
      chk("cw pin reset", got, CW_DEFAULT);
      $display("pin reset test done");
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Watchdog: the sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      conclude();
   end
   initial begin
      rst = 1'b1;
      cfg = 1'b1;
      busy = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = '0;
      wdata = '0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      step(6);
      t_reset();
      t_pairs();
      t_hw();
      t_standby_n_pin();
      t_doze();
      t_pinrst();
      conclude();
   end
endmodule
